// ---- hw/typec_src_pkg.sv ----
// Shared constants, types and register map for the Type-C source attach controller
package typec_src_pkg;

  // Core clock rate
  localparam int unsigned CLK_HZ          = 10_000_000;

  // Settle time of the filtered CC terminations, in microseconds
  localparam int unsigned CC_DEBOUNCE_US  = 100;
  localparam int unsigned CC_DEBOUNCE_CYC = (CC_DEBOUNCE_US * (CLK_HZ / 1_000_000) < 1) ? 1 :
                                            CC_DEBOUNCE_US * (CLK_HZ / 1_000_000);

  // APB register byte offsets
  localparam int unsigned      APB_AW          = 8;
  localparam logic [APB_AW-1:0] ADDR_STATUS     = 8'h00;
  localparam logic [APB_AW-1:0] ADDR_IRQ_STATUS = 8'h04;
  localparam logic [APB_AW-1:0] ADDR_IRQ_ENABLE = 8'h08;
  localparam logic [APB_AW-1:0] ADDR_IRQ_CLEAR  = 8'h0C;

  // Event bits, shared by the status, enable and clear registers
  localparam int unsigned EVT_W          = 4;
  localparam int unsigned EVT_ATTACH     = 0;
  localparam int unsigned EVT_DETACH     = 1;
  localparam int unsigned EVT_FAULT_RISE = 2;
  localparam int unsigned EVT_FAULT_FALL = 3;
  localparam logic [EVT_W-1:0] IRQ_ENABLE_RST = 4'h0;

  // Live status register bit positions
  localparam int unsigned STAT_ATTACHED  = 0;
  localparam int unsigned STAT_FLIPPED   = 1;
  localparam int unsigned STAT_VBUS_ON   = 2;
  localparam int unsigned STAT_VCONN_CC1 = 3;
  localparam int unsigned STAT_VCONN_CC2 = 4;
  localparam int unsigned STAT_FAULT     = 5;
  localparam int unsigned STAT_ADV_1P5A  = 6;
  localparam int unsigned STAT_ENABLED   = 7;
  localparam int unsigned STAT_CC_LSB    = 8;

  // Filtered termination seen on each CC line
  typedef struct packed {
    logic cc2_ra;
    logic cc2_rd;
    logic cc1_ra;
    logic cc1_rd;
  } cc_term_t;

  // Sticky event layout
  typedef struct packed {
    logic fault_fall;
    logic fault_rise;
    logic detach;
    logic attach;
  } evt_t;

  // Port connection states
  typedef enum logic [2:0] {
    ST_DISABLED   = 3'b001,
    ST_UNATTACHED = 3'b010,
    ST_ATTACHED   = 3'b100
  } attach_state_t;

endpackage : typec_src_pkg

// ---- hw/pin_sync2.sv ----
// Two flip-flop synchroniser for a group of asynchronous pin levels
`timescale 1ns/100ps
module pin_sync2 #(
  parameter int unsigned W = 1
) (
  input  wire logic         i_core_clk,  // Core clock
  input  wire logic         i_rst_n,     // Async reset, active low
  input  wire logic [W-1:0] i_async,     // Raw pin levels
  output logic      [W-1:0] o_sync       // Synchronised levels
);

  logic [W-1:0] meta_q;

  // First stage feeds only the second stage
  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      meta_q <= '0;
      o_sync <= '0;
    end else begin
      meta_q <= i_async;
      o_sync <= meta_q;
    end
  end

endmodule : pin_sync2

// ---- hw/term_filter.sv ----
// Settle filter: passes the CC termination pattern once it has held steady
`timescale 1ns/100ps
module term_filter
  import typec_src_pkg::*;
#(
  parameter int unsigned CYC = CC_DEBOUNCE_CYC
) (
  input  wire logic     i_core_clk,  // Core clock
  input  wire logic     i_rst_n,     // Async reset, active low
  input  wire cc_term_t i_raw,       // Synchronised terminations
  output cc_term_t      o_stable     // Settled terminations
);

  localparam int unsigned CW = $clog2(CYC + 1);
  localparam logic [CW-1:0] CNT_MAX = CW'(CYC);

  cc_term_t        last_q;
  logic [CW-1:0]   cnt_q;

  // Restart the count on any change; plug bounce never reaches the state machine
  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      last_q   <= '0;
      cnt_q    <= '0;
      o_stable <= '0;
    end else if (i_raw != last_q) begin
      last_q <= i_raw;
      cnt_q  <= '0;
    end else if (cnt_q != CNT_MAX) begin
      cnt_q <= cnt_q + 1'b1;
    end else begin
      o_stable <= last_q;
    end
  end

endmodule : term_filter

// ---- hw/typec_source_attach_ctrl.sv ----
// Type-C source attach, orientation, VCONN and fault flag logic with APB registers
//
// Behaviour
// (RULE_01) Watch both CC lines continuously while enabled
// (RULE_02) Rd on either line means sink attached
// (RULE_03) No termination: VBUS, VCONN off, flags released
// (RULE_04) On attach: VBUS on, attached flag low
// (RULE_05) Orientation flag low only for Rd on CC2
// (RULE_06) Rd plus Ra: VCONN on the Ra line
// (RULE_07) Ra alone: no VBUS, VCONN or flags
// (RULE_08) Another source: stay off, keep waiting
// (RULE_09) Detect detach, orientation and attached type
// (RULE_10) Fault flag low on over-current
// (RULE_11) Fault flag low on either thermal trip
// (RULE_12) Fault clears itself when conditions normalise
// (RULE_13) Select input picks default or 1.5 A advert
// (RULE_14) Outside controller drives the enable input
// (RULE_15) Three flags active low, released when inactive
// (RULE_16) Build option that never supplies VCONN
// (RULE_17) Disabled: outputs off, all flags released
//
// Local design decisions: the placing of the registers and the APB slave port.
`timescale 1ns/100ps
module typec_source_attach_ctrl
  import typec_src_pkg::*;
#(
  parameter bit VCONN_SUPPORT = 1'b1  // Clear for the variant without VCONN
) (
  input  wire logic              i_core_clk,                // Core clock, 10 MHz
  input  wire logic              i_rst_n,                   // Async reset, active low
  // APB slave
  input  wire logic              psel,                      // Slave select
  input  wire logic              penable,                   // Access phase
  input  wire logic              pwrite,                    // Write when high
  input  wire logic [APB_AW-1:0] paddr,                     // Byte address
  input  wire logic [31:0]       pwdata,                    // Write data
  output logic      [31:0]       prdata,                    // Read data
  output logic                   pready,                    // Transfer done
  output logic                   pslverr,                   // Unmapped address or wrong access direction
  // Pin inputs, asynchronous
  input  wire logic              i_enable,                  // Device enable, high on
  input  wire logic              i_current_advert_select,   // High selects 1.5 A advert
  input  wire logic              i_cc1_rd,                  // Rd sensed on CC1
  input  wire logic              i_cc1_ra,                  // Ra sensed on CC1
  input  wire logic              i_cc2_rd,                  // Rd sensed on CC2
  input  wire logic              i_cc2_ra,                  // Ra sensed on CC2
  input  wire logic              i_over_current,            // Output above current limit
  input  wire logic              i_therm_dev_trip,          // Device shutdown temperature
  input  wire logic              i_therm_ilim_trip,         // Switch shutdown temp in limit
  // Power path controls
  output logic                   o_vbus_switch_on,          // Connect supply_input to VBUS
  output logic                   o_vconn_cc1_on,            // VCONN onto CC1
  output logic                   o_vconn_cc2_on,            // VCONN onto CC2
  output logic                   o_advert_1p5a,             // 1 = 1.5 A, 0 = default_current_level
  // Open-drain flags
  output logic                   o_fault_n_o,               // Fault flag drive level
  output logic                   o_fault_n_oe,              // Fault flag pulled low
  output logic                   o_sink_attached_n_o,       // Attached flag drive level
  output logic                   o_sink_attached_n_oe,      // Attached flag pulled low
  output logic                   o_orientation_flipped_n_o, // Orientation flag drive level
  output logic                   o_orientation_flipped_n_oe,// Orientation flag pulled low
  output logic                   o_irq                      // Level interrupt
);

  // Rd present on the line selected by orientation
  function automatic logic rd_on_line(input cc_term_t t, input logic flip);
    rd_on_line = flip ? t.cc2_rd : t.cc1_rd;
  endfunction : rd_on_line

  // Any sink pull-down on either line
  function automatic logic sink_seen(input cc_term_t t);
    sink_seen = t.cc1_rd | t.cc2_rd;
  endfunction : sink_seen

  // Synchronised pins
  logic [8:0]     pins_s;
  cc_term_t       cc_s;
  cc_term_t       cc_f;
  logic           en_s;
  logic           sel_s;
  logic           oc_s;
  logic           tdev_s;
  logic           tilim_s;
  logic           fault_any;
  logic           shut_any;

  attach_state_t  state_q;
  attach_state_t  state_d;
  logic           flip_q;
  logic           flip_d;
  logic           fault_q;
  logic [EVT_W-1:0] irq_stat_q;
  logic [EVT_W-1:0] irq_en_q;
  evt_t           evt;
  logic [31:0]    status_w;
  logic           vconn1_d;
  logic           vconn2_d;

  // APB decode
  logic           setup;
  logic           acc;
  logic           wr_en;
  logic           rd_hit;
  logic           wr_hit;

  // All pins pass two flops first
  pin_sync2 #(
    .W (9)
  ) u_sync (
    .i_core_clk (i_core_clk),
    .i_rst_n    (i_rst_n),
    .i_async    ({i_therm_ilim_trip, i_therm_dev_trip, i_over_current,
                  i_current_advert_select, i_enable,
                  i_cc2_ra, i_cc2_rd, i_cc1_ra, i_cc1_rd}),
    .o_sync     (pins_s)
  );

  assign cc_s    = cc_term_t'(pins_s[3:0]);
  assign en_s    = pins_s[4];
  assign sel_s   = pins_s[5];
  assign oc_s    = pins_s[6];
  assign tdev_s  = pins_s[7];
  assign tilim_s = pins_s[8];

  // Terminations settle before they can attach or detach
  term_filter #(
    .CYC (CC_DEBOUNCE_CYC)
  ) u_filt (
    .i_core_clk (i_core_clk),
    .i_rst_n    (i_rst_n),
    .i_raw      (cc_s),
    .o_stable   (cc_f)
  );

  // Fault sources; thermal trips also open the switches
  assign fault_any = oc_s | tdev_s | tilim_s;  // RULE_10 RULE_11
  assign shut_any  = tdev_s | tilim_s;          // RULE_11

  // Attach state machine
  always_comb begin
    state_d = state_q;
    flip_d  = flip_q;
    unique case (state_q)
      ST_DISABLED: begin
        if (en_s) begin
          state_d = ST_UNATTACHED;
        end
      end
      ST_UNATTACHED: begin
        // Ra only or a second source leaves us waiting here
        if (!en_s) begin
          state_d = ST_DISABLED;                           // RULE_17
        end else if (sink_seen(cc_f)) begin                 // RULE_01 RULE_02 RULE_07 RULE_08
          state_d = ST_ATTACHED;
          flip_d  = !cc_f.cc1_rd;                          // RULE_05 RULE_09
        end
      end
      ST_ATTACHED: begin
        if (!en_s) begin
          state_d = ST_DISABLED;                           // RULE_17
        end else if (!rd_on_line(cc_f, flip_q)) begin
          state_d = ST_UNATTACHED;                         // RULE_09
        end
      end
      default: begin
        state_d = ST_UNATTACHED;
      end
    endcase
  end

  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      state_q <= ST_DISABLED;
      flip_q  <= 1'b0;
    end else begin
      state_q <= state_d;
      flip_q  <= flip_d;
    end
  end

  // VCONN goes to the Ra line opposite the sink, unless the build omits it
  assign vconn1_d = VCONN_SUPPORT && state_d == ST_ATTACHED && flip_d && cc_f.cc1_ra;   // RULE_06 RULE_16
  assign vconn2_d = VCONN_SUPPORT && state_d == ST_ATTACHED && !flip_d && cc_f.cc2_ra;  // RULE_06 RULE_16

  // Power switches, registered from the next state
  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_vbus_switch_on <= 1'b0;
      o_vconn_cc1_on   <= 1'b0;
      o_vconn_cc2_on   <= 1'b0;
    end else begin
      o_vbus_switch_on <= state_d == ST_ATTACHED && !shut_any;  // RULE_03 RULE_04 RULE_11
      o_vconn_cc1_on   <= vconn1_d && !shut_any;
      o_vconn_cc2_on   <= vconn2_d && !shut_any;
    end
  end

  // Open-drain flags only ever pull low
  assign o_fault_n_o               = 1'b0;
  assign o_sink_attached_n_o       = 1'b0;
  assign o_orientation_flipped_n_o = 1'b0;

  // Flag enables and advert level
  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_sink_attached_n_oe       <= 1'b0;
      o_orientation_flipped_n_oe <= 1'b0;
      o_advert_1p5a              <= 1'b0;
    end else begin
      o_sink_attached_n_oe       <= state_d == ST_ATTACHED;            // RULE_04 RULE_15
      o_orientation_flipped_n_oe <= state_d == ST_ATTACHED && flip_d;  // RULE_05 RULE_15
      o_advert_1p5a              <= en_s && sel_s;                     // RULE_13
    end
  end

  // Fault follows its sources with no clear; released while disabled
  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      fault_q <= 1'b0;
    end else begin
      fault_q <= fault_any && en_s;  // RULE_10 RULE_11 RULE_12 RULE_17
    end
  end

  assign o_fault_n_oe = fault_q;

  // Events for the interrupt status
  assign evt.attach     = state_q != ST_ATTACHED && state_d == ST_ATTACHED;
  assign evt.detach     = state_q == ST_ATTACHED && state_d != ST_ATTACHED;
  assign evt.fault_rise = !fault_q && fault_any && en_s;
  assign evt.fault_fall = fault_q && !(fault_any && en_s);

  // Live status view
  always_comb begin
    status_w                 = '0;
    status_w[STAT_ATTACHED]  = state_q == ST_ATTACHED;
    status_w[STAT_FLIPPED]   = flip_q && state_q == ST_ATTACHED;  // RULE_09 Stale orientation hidden once detached
    status_w[STAT_VBUS_ON]   = o_vbus_switch_on;
    status_w[STAT_VCONN_CC1] = o_vconn_cc1_on;
    status_w[STAT_VCONN_CC2] = o_vconn_cc2_on;
    status_w[STAT_FAULT]     = fault_q;
    status_w[STAT_ADV_1P5A]  = o_advert_1p5a;
    status_w[STAT_ENABLED]   = en_s;
    status_w[STAT_CC_LSB +: 4] = cc_f;
  end

  // APB: zero wait states, read data captured in the setup cycle
  assign setup   = psel && !penable;
  assign acc     = psel && penable;
  assign wr_en   = acc && pwrite;
  assign rd_hit  = paddr == ADDR_STATUS || paddr == ADDR_IRQ_STATUS || paddr == ADDR_IRQ_ENABLE;
  assign wr_hit  = paddr == ADDR_IRQ_ENABLE || paddr == ADDR_IRQ_CLEAR;
  assign pready  = 1'b1;
  assign pslverr = acc && (pwrite ? !wr_hit : !rd_hit);

  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      prdata <= 32'h0000_0000;
    end else if (setup) begin
      unique case (paddr)
        ADDR_STATUS:     prdata <= status_w;
        ADDR_IRQ_STATUS: prdata <= {28'h000_0000, irq_stat_q};
        ADDR_IRQ_ENABLE: prdata <= {28'h000_0000, irq_en_q};
        default:         prdata <= 32'h0000_0000;
      endcase
    end
  end

  // Interrupt enable register
  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      irq_en_q <= IRQ_ENABLE_RST;
    end else if (wr_en && paddr == ADDR_IRQ_ENABLE) begin
      irq_en_q <= pwdata[EVT_W-1:0];
    end
  end

  // Sticky status; a new event beats a clear in the same cycle
  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      irq_stat_q <= '0;
    end else if (wr_en && paddr == ADDR_IRQ_CLEAR) begin
      irq_stat_q <= (irq_stat_q & ~pwdata[EVT_W-1:0]) | evt;
    end else begin
      irq_stat_q <= irq_stat_q | evt;
    end
  end

  assign o_irq = |(irq_stat_q & irq_en_q);

  // Checks

  property p_idle_quiet;
    @(posedge i_core_clk) disable iff (!i_rst_n)
    (state_q != ST_ATTACHED) ##1 (state_q != ST_ATTACHED) |->
      !o_vbus_switch_on && !o_vconn_cc1_on && !o_vconn_cc2_on && !o_sink_attached_n_oe;
  endproperty
  a_idle_quiet: assert property (p_idle_quiet) else $error("Outputs active while unattached"); // RULE_03

  property p_attach_on;
    @(posedge i_core_clk) disable iff (!i_rst_n)
    (state_q == ST_UNATTACHED && en_s && sink_seen(cc_f) && !shut_any) |=>
      o_vbus_switch_on && o_sink_attached_n_oe && state_q == ST_ATTACHED;
  endproperty
  a_attach_on: assert property (p_attach_on) else $error("Attach did not switch VBUS on"); // RULE_04

  property p_orient;
    @(posedge i_core_clk) disable iff (!i_rst_n)
    (state_q == ST_UNATTACHED && en_s && cc_f.cc2_rd && !cc_f.cc1_rd) |=>
      o_orientation_flipped_n_oe ##1 (o_orientation_flipped_n_oe || !o_sink_attached_n_oe);
  endproperty
  a_orient: assert property (p_orient) else $error("Flipped attach not flagged"); // RULE_05

  property p_orient_cc1;
    @(posedge i_core_clk) disable iff (!i_rst_n)
    (state_q == ST_UNATTACHED && en_s && cc_f.cc1_rd) |=> !o_orientation_flipped_n_oe;
  endproperty
  a_orient_cc1: assert property (p_orient_cc1) else $error("CC1 attach flagged flipped"); // RULE_05

  property p_vconn_ra;
    @(posedge i_core_clk) disable iff (!i_rst_n)
    o_vconn_cc2_on |-> $past(cc_f.cc2_ra) && $past(cc_f.cc1_rd) && o_vbus_switch_on;
  endproperty
  a_vconn_ra: assert property (p_vconn_ra) else $error("VCONN on a line without Ra"); // RULE_06

  property p_no_rd_off;
    @(posedge i_core_clk) disable iff (!i_rst_n)
    !sink_seen(cc_f) |=> !o_vbus_switch_on && !o_vconn_cc1_on && !o_vconn_cc2_on;
  endproperty
  a_no_rd_off: assert property (p_no_rd_off) else $error("Output on without Rd"); // RULE_07

  property p_fault_set;
    @(posedge i_core_clk) disable iff (!i_rst_n)
    (en_s && (oc_s || tdev_s || tilim_s)) |=> o_fault_n_oe;
  endproperty
  a_fault_set: assert property (p_fault_set) else $error("Fault flag not asserted"); // RULE_10

  property p_therm_off;
    @(posedge i_core_clk) disable iff (!i_rst_n)
    (tdev_s || tilim_s) |=> !o_vbus_switch_on && !o_vconn_cc1_on && !o_vconn_cc2_on;
  endproperty
  a_therm_off: assert property (p_therm_off) else $error("Switch on during thermal trip"); // RULE_11

  property p_fault_clear;
    @(posedge i_core_clk) disable iff (!i_rst_n)
    $fell(fault_any) |=> !o_fault_n_oe;
  endproperty
  a_fault_clear: assert property (p_fault_clear) else $error("Fault flag stuck"); // RULE_12

  property p_advert;
    @(posedge i_core_clk) disable iff (!i_rst_n)
    en_s |=> o_advert_1p5a == $past(sel_s);
  endproperty
  a_advert: assert property (p_advert) else $error("Advert level wrong"); // RULE_13

  property p_no_vconn_build;
    @(posedge i_core_clk) disable iff (!i_rst_n)
    !VCONN_SUPPORT |-> !o_vconn_cc1_on && !o_vconn_cc2_on;
  endproperty
  a_no_vconn_build: assert property (p_no_vconn_build) else $error("VCONN in no-VCONN build"); // RULE_16

  property p_disabled;
    @(posedge i_core_clk) disable iff (!i_rst_n)
    !en_s |=> !o_vbus_switch_on && !o_fault_n_oe && !o_sink_attached_n_oe && !o_orientation_flipped_n_oe;
  endproperty
  a_disabled: assert property (p_disabled) else $error("Active while disabled"); // RULE_17

endmodule : typec_source_attach_ctrl

// ---- sim/cc_far_end.sv ----
// Far-end model: sink, plain or marked cable, or another source on the CC lines
`timescale 1ns/100ps
module cc_far_end (
  input  wire logic       i_core_clk, // Core clock
  input  wire logic [2:0] i_mode,     // Attachment chosen by the bench
  input  wire logic       i_slow,     // New pattern lands late
  output logic      [3:0] o_term      // {cc2_ra, cc2_rd, cc1_ra, cc1_rd}
);
  logic [3:0] want;
  logic [3:0] lag_q  = 4'h0;
  int         wait_q = 0;
  // Pattern per attachment; another source shows no pull-down at all
  always_comb begin
    case (i_mode)
      3'h1: want = 4'h1;    // Sink, Rd on CC1
      3'h2: want = 4'h4;    // Sink, Rd on CC2
      3'h3: want = 4'h8;    // Marked cable alone, Ra on CC2
      3'h4: want = 4'h2;    // Marked cable alone, Ra on CC1
      3'h5: want = 4'h9;    // Sink through marked cable
      3'h6: want = 4'h6;    // Same, flipped
      default: want = 4'h0; // Nothing, or another source
    endcase
  end
  // A slow plug holds the old pattern a few cycles, so settling is exercised
  always @(posedge i_core_clk) begin
    if (want != lag_q && wait_q < (i_slow ? 8 : 0)) wait_q <= wait_q + 1;
    else begin
      lag_q  <= want;
      wait_q <= 0;
    end
  end
  assign o_term = lag_q;
endmodule : cc_far_end

// ---- sim/typec_source_attach_ctrl_tb_top.sv ----
// Self-checking bench for the source attach controller and its no-VCONN variant
`timescale 1ns/100ps
module typec_source_attach_ctrl_tb_top;
  import typec_src_pkg::*;
  logic i_core_clk = 1'b0, i_rst_n = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, pready, pslverr, o_irq;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0000_0000, prdata, rd;
  logic i_enable = 1'b1, i_current_advert_select = 1'b0, i_over_current = 1'b0;
  logic i_therm_dev_trip = 1'b0, i_therm_ilim_trip = 1'b0, slow = 1'b0, err;
  logic [2:0] mode = 3'h0;
  logic [3:0] term;
  logic o_vbus_switch_on, o_vconn_cc1_on, o_vconn_cc2_on, o_advert_1p5a, o_fault_n_oe;
  logic o_sink_attached_n_oe, o_orientation_flipped_n_oe, nv_vbus, nv_vc1, nv_vc2;
  logic lvl_f, lvl_s, lvl_o;
  int num_errors = 0, total_checks = 0;
  wire [4:0] seen_pins = {o_vconn_cc2_on, o_vconn_cc1_on, o_vbus_switch_on, o_orientation_flipped_n_oe,
                          o_sink_attached_n_oe};
  always #50 i_core_clk = ~i_core_clk;
  cc_far_end FAR (.i_core_clk, .i_mode(mode), .i_slow(slow), .o_term(term));
  typec_source_attach_ctrl DUT (.i_core_clk, .i_rst_n, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .i_enable, .i_current_advert_select, .i_cc1_rd(term[0]), .i_cc1_ra(term[1]),
    .i_cc2_rd(term[2]), .i_cc2_ra(term[3]), .i_over_current, .i_therm_dev_trip, .i_therm_ilim_trip,
    .o_vbus_switch_on, .o_vconn_cc1_on, .o_vconn_cc2_on, .o_advert_1p5a, .o_fault_n_o(lvl_f), .o_fault_n_oe,
    .o_sink_attached_n_o(lvl_s), .o_sink_attached_n_oe, .o_orientation_flipped_n_o(lvl_o),
    .o_orientation_flipped_n_oe, .o_irq);
  // Variant without VCONN sees the same pins; its bus is parked
  typec_source_attach_ctrl #(.VCONN_SUPPORT(1'b0)) DUT_NOVC (.i_core_clk, .i_rst_n, .psel(1'b0),
    .penable(1'b0), .pwrite(1'b0), .paddr, .pwdata, .prdata(), .pready(), .pslverr(),
    .i_enable, .i_current_advert_select, .i_cc1_rd(term[0]), .i_cc1_ra(term[1]), .i_cc2_rd(term[2]),
    .i_cc2_ra(term[3]), .i_over_current, .i_therm_dev_trip, .i_therm_ilim_trip, .o_vbus_switch_on(nv_vbus),
    .o_vconn_cc1_on(nv_vc1), .o_vconn_cc2_on(nv_vc2), .o_advert_1p5a(), .o_fault_n_o(), .o_fault_n_oe(),
    .o_sink_attached_n_o(), .o_sink_attached_n_oe(), .o_orientation_flipped_n_o(),
    .o_orientation_flipped_n_oe(), .o_irq());
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("[FAIL] %0t ns: seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic report_and_stop;
    if (num_errors == 0 && total_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : report_and_stop
  // Expected {vconn_cc2, vconn_cc1, vbus, flipped, attached} for an attachment
  function automatic logic [4:0] expect_pins(input logic [2:0] m, input logic en);
    if (!en) return 5'h00;
    case (m)
      3'h1: return 5'h05;
      3'h2: return 5'h07;
      3'h5: return 5'h15;
      3'h6: return 5'h0F;
      default: return 5'h00;
    endcase
  endfunction : expect_pins
  // One APB transfer; request held until pready is seen at a rising edge
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    int n;
    n = 0;
    @(posedge i_core_clk);
    psel <= 1'b1; penable <= 1'b0; pwrite <= wr; paddr <= a; pwdata <= wd;
    @(posedge i_core_clk);
    penable <= 1'b1;
    do begin
      @(posedge i_core_clk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0; penable <= 1'b0;
    #1;
    check({31'h0, pready}, 32'h1);
  endtask : apb
  // Apply an attachment, let it settle, then check pins and the status word
  task automatic settle(input logic [2:0] m);
    logic [4:0] exp_p;
    @(posedge i_core_clk);
    mode <= m; i_current_advert_select <= 1'($urandom); slow <= 1'($urandom);
    repeat (1030) @(posedge i_core_clk);
    #1;
    exp_p = expect_pins(m, i_enable);
    check({27'h0, seen_pins}, {27'h0, exp_p});
    check({30'h0, nv_vc2, nv_vc1}, 32'h0);
    check({31'h0, nv_vbus}, {31'h0, exp_p[2]});
    check({31'h0, o_advert_1p5a}, {31'h0, i_current_advert_select & i_enable});
    check({29'h0, lvl_f, lvl_s, lvl_o}, 32'h0);
    apb(1'b0, ADDR_STATUS, 32'h0);
    check({21'h0, rd[11:8], rd[7:6], rd[4:0]}, {21'h0, term, i_enable, i_current_advert_select & i_enable,
                                                exp_p});
  endtask : settle
  initial begin
    void'($urandom(32'hc07d_21b9));
    repeat (16) @(posedge i_core_clk);
    i_rst_n <= 1'b1;
    apb(1'b0, ADDR_IRQ_ENABLE, 32'h0);
    check(rd, {28'h0, IRQ_ENABLE_RST});
    apb(1'b0, 8'h10, 32'h0);
    check(rd, 32'h0);
    check({31'h0, err}, 32'h1);
    apb(1'b1, ADDR_STATUS, 32'hFFFF_FFFF);
    check({31'h0, err}, 32'h1);
    // Every attachment from a clean detach, then random ones; source and cable alone stay off
    for (int i = 0; i < 12; i++) begin
      settle(3'h0);
      settle(i < 8 ? 3'(i) : 3'($urandom_range(7, 0)));
    end
    // Attach event is sticky, masked, then unmasked and cleared
    settle(3'h0);
    apb(1'b1, ADDR_IRQ_CLEAR, 32'hF);
    settle(3'h5);
    check({31'h0, o_irq}, 32'h0);
    apb(1'b0, ADDR_IRQ_STATUS, 32'h0);
    check(rd, 32'h1 << EVT_ATTACH);
    apb(1'b1, ADDR_IRQ_ENABLE, 32'hF);
    check({31'h0, o_irq}, 32'h1);
    apb(1'b1, ADDR_IRQ_CLEAR, 32'h1);
    check({31'h0, o_irq}, 32'h0);
    // Over-current keeps switches; either thermal trip opens them; all clear on their own
    for (int k = 0; k < 3; k++) begin
      @(posedge i_core_clk);
      {i_therm_ilim_trip, i_therm_dev_trip, i_over_current} <= 3'h1 << k;
      repeat (4) @(posedge i_core_clk);
      #1;
      check({30'h0, o_fault_n_oe, o_vbus_switch_on}, {30'h0, 1'b1, k == 0});
      @(posedge i_core_clk);
      {i_therm_ilim_trip, i_therm_dev_trip, i_over_current} <= 3'h0;
      repeat (4) @(posedge i_core_clk);
      #1;
      check({30'h0, o_fault_n_oe, o_vbus_switch_on}, 32'h1);
    end
    // Disabled with a fault pending: everything off and released
    @(posedge i_core_clk);
    i_enable <= 1'b0; i_over_current <= 1'b1;
    settle(3'h6);
    check({31'h0, o_fault_n_oe}, 32'h0);
    @(posedge i_core_clk);
    i_enable <= 1'b1; i_over_current <= 1'b0;
    settle(3'h6);
    report_and_stop;
  end
  // Watchdog over roughly two and a half times the expected run
  initial begin
    repeat (70000) @(posedge i_core_clk);
    num_errors++;
    report_and_stop;
  end
endmodule : typec_source_attach_ctrl_tb_top
